// [verilog/pin_irq_defs.svh]
// register offsets, field positions and reset values of the pin interrupt block
`ifndef PIN_IRQ_DEFS_SVH
`define PIN_IRQ_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define FIRST_FLAG_ADDR 8'h89
`define SECOND_FLAG_ADDR 8'h8a
`define THIRD_FLAG_ADDR 8'h8b
`define PIN_CTRL_ADDR 8'h8c
`define SECOND_PIN_EN_ADDR 8'h8d
`define EVT_STATUS_ADDR 8'h90
`define EVT_CLEAR_ADDR 8'h91
`define EVT_ENABLE_ADDR 8'h92

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define CTRL_RESET 7'h00
`define FLAG_RESET 21'h000000
`define SECOND_PIN_EN_RESET 8'h00
`define EVT_RESET 3'h0
`define FIRST_LO 0
`define SECOND_LO 8
`define THIRD_LO 16
`define RESUME_LINE 7
`define SPARE_FLAG_LINE 6
`define FIRST_FLAG_MASK_USB 8'hbf
`define FIRST_FLAG_MASK_STD 8'hff

`endif

// [verilog/pin_irq_pkg.sv]
// types shared by the pin interrupt block
package pin_irq_pkg;

   // control register fields, bit 6 first down to bit 0
   typedef struct packed {
      logic spare;
      logic third_en;
      logic upper_en;
      logic lower_en;
      logic third_edge;
      logic second_edge;
      logic first_edge;
   } pin_ctrl_t;

   // one register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } bus_req_t;

endpackage

// [verilog/edge_sync.sv]
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
   parameter int W = 21
) (
   input wire logic sys_clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic [W-1:0] async_i, // raw pin levels
   output logic [W-1:0] rise_o, // one-cycle rising pulse
   output logic [W-1:0] fall_o // one-cycle falling pulse
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] filt_ff;
   logic [W-1:0] prev_ff;

   // sync chain; only s2 reads s1
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= async_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // a level counts once stages two and three agree
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt_ff <= '0;
         prev_ff <= '0;
      end else begin
         filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
         prev_ff <= filt_ff;
      end
   end

   // current against previous sample
   assign rise_o = filt_ff & ~prev_ff;
   assign fall_o = ~filt_ff & prev_ff;

   a_pulse_single: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rise_o[0] |=> !rise_o[0]) else $error("rise pulse longer than one cycle");
   a_edge_cause: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      fall_o[0] |-> !$past(s2_ff[0]) && !$past(s3_ff[0]))
      else $error("fall without agreement of stages two and three");
endmodule
`default_nettype wire

// [verilog/port_pin_interrupt_control.sv]
// edge interrupt control for three input ports with register access
`timescale 1ns/1ps
`default_nettype none
`include "pin_irq_defs.svh"
module port_pin_interrupt_control #(
   parameter bit HAS_USB = 1'b1 // build with internal resume source
) (
   input wire logic sys_clk_i, // system clock, 10 MHz
   input wire logic rst_n_i, // async reset, active low
   input wire pin_irq_pkg::bus_req_t bus_i, // register request
   output logic [7:0] rd_data_o, // read data, cycle after strobe
   input wire logic [7:0] first_port_i, // first port pins
   input wire logic [7:0] second_port_i, // second port pins
   input wire logic [4:0] third_port_i, // third port pins
   input wire logic usb_resume_i, // internal resume level, same clock
   output logic irq_o, // level interrupt
   output logic [2:0] port_irq_o, // per-port request: third, second, first
   output pin_irq_pkg::pin_ctrl_t ctrl_o // control register image
);
   import pin_irq_pkg::*;

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   pin_ctrl_t ctrl_ff;
   logic [20:0] flag_ff;
   logic [7:0] pin_en_ff;
   logic [2:0] evt_stat_ff;
   logic [2:0] evt_en_ff;
   logic [7:0] rd_ff;
   logic irq_ff;
   logic [2:0] port_irq_ff;
   logic usb_prev_ff;

   // ----------------------------------------------------------------------------
   // next values and decode
   // ----------------------------------------------------------------------------
   pin_ctrl_t nxt_ctrl;
   logic [20:0] nxt_flag;
   logic [7:0] nxt_pin_en;
   logic [2:0] nxt_evt_stat;
   logic [2:0] nxt_evt_en;
   logic [2:0] nxt_port_irq;
   logic [20:0] rise;
   logic [20:0] fall;
   logic [20:0] edge_ev;
   logic [20:0] flag_clr;
   logic [20:0] flag_mask;
   logic [7:0] first_ev;
   logic [7:0] first_grp;
   logic usb_rise;
   logic usb_fall;
   logic wr_ctrl;
   logic wr_first;
   logic wr_second;
   logic wr_third;
   logic wr_pin_en;
   logic wr_evt_clr;
   logic wr_evt_en;
   logic [2:0] evt_new;

   // register write decode
   assign wr_ctrl = bus_i.we && (bus_i.addr == `PIN_CTRL_ADDR);
   assign wr_first = bus_i.we && (bus_i.addr == `FIRST_FLAG_ADDR);
   assign wr_second = bus_i.we && (bus_i.addr == `SECOND_FLAG_ADDR);
   assign wr_third = bus_i.we && (bus_i.addr == `THIRD_FLAG_ADDR);
   assign wr_pin_en = bus_i.we && (bus_i.addr == `SECOND_PIN_EN_ADDR);
   assign wr_evt_clr = bus_i.we && (bus_i.addr == `EVT_CLEAR_ADDR);
   assign wr_evt_en = bus_i.we && (bus_i.addr == `EVT_ENABLE_ADDR);

   // ----------------------------------------------------------------------------
   // input synchronisers and edge detection
   // ----------------------------------------------------------------------------
   edge_sync #(
      .W(21)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .async_i({third_port_i, second_port_i, first_port_i}),
      .rise_o(rise),
      .fall_o(fall)
   );

   // resume comes from logic on this clock, so no synchroniser
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         usb_prev_ff <= 1'b0;
      end else begin
         usb_prev_ff <= usb_resume_i;
      end
   end

   assign usb_rise = usb_resume_i && !usb_prev_ff;
   assign usb_fall = !usb_resume_i && usb_prev_ff;

   // first port edges, with line 7 taken over by resume on the usb build;
   // resume follows the same edge select, so software must hold it rising
   always_comb begin
      first_ev = ctrl_ff.first_edge ? fall[7:0] : rise[7:0];
      if (HAS_USB) begin
         first_ev[`RESUME_LINE] = ctrl_ff.first_edge ? usb_fall : usb_rise;
         first_ev[`SPARE_FLAG_LINE] = 1'b0;
      end
   end

   // per-port polarity
   assign edge_ev[7:0] = first_ev;
   assign edge_ev[15:8] = ctrl_ff.second_edge ? fall[15:8] : rise[15:8];
   assign edge_ev[20:16] = ctrl_ff.third_edge ? fall[20:16] : rise[20:16];

   // ----------------------------------------------------------------------------
   // pending flags
   // ----------------------------------------------------------------------------
   // usb build keeps flag 6 at zero; pins 7 and 6 are not flagged there
   assign flag_mask[7:0] = HAS_USB ? `FIRST_FLAG_MASK_USB : `FIRST_FLAG_MASK_STD;
   assign flag_mask[20:8] = '1;

   // writing 0 clears a flag, writing 1 leaves it
   assign flag_clr[7:0] = wr_first ? ~bus_i.wdata : 8'h00;
   assign flag_clr[15:8] = wr_second ? ~bus_i.wdata : 8'h00;
   assign flag_clr[20:16] = wr_third ? ~bus_i.wdata[4:0] : 5'h00;

   // set beats clear in the same cycle so no edge is lost
   genvar gi;
   generate
      for (gi = 0; gi < 21; gi = gi + 1) begin : g_flag
         assign nxt_flag[gi] = flag_mask[gi] &&
            ((flag_ff[gi] && !flag_clr[gi]) || edge_ev[gi]);
      end
   endgenerate

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_ff <= `FLAG_RESET;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // ----------------------------------------------------------------------------
   // control and enable registers
   // ----------------------------------------------------------------------------
   // bit 7 is not stored; bit 6 is kept without function
   assign nxt_ctrl = wr_ctrl ? pin_ctrl_t'(bus_i.wdata[6:0]) : ctrl_ff;
   assign nxt_pin_en = wr_pin_en ? bus_i.wdata : pin_en_ff;
   assign nxt_evt_en = wr_evt_en ? bus_i.wdata[2:0] : evt_en_ff;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= `CTRL_RESET;
         pin_en_ff <= `SECOND_PIN_EN_RESET;
         evt_en_ff <= `EVT_RESET;
      end else begin
         ctrl_ff <= nxt_ctrl;
         pin_en_ff <= nxt_pin_en;
         evt_en_ff <= nxt_evt_en;
      end
   end

   // ----------------------------------------------------------------------------
   // group gating and per-port requests
   // ----------------------------------------------------------------------------
   // gating uses the new control value so requests track it exactly
   assign first_grp = {{4{nxt_ctrl.upper_en}}, {4{nxt_ctrl.lower_en}}};
   assign nxt_port_irq[0] = |(nxt_flag[7:0] & first_grp);
   assign nxt_port_irq[1] = |(nxt_flag[15:8] & nxt_pin_en);
   assign nxt_port_irq[2] = nxt_ctrl.third_en && (|nxt_flag[20:16]);

   // a new qualified edge per port feeds the sticky event bits
   assign evt_new[0] = |(edge_ev[7:0] & flag_mask[7:0] &
      {{4{ctrl_ff.upper_en}}, {4{ctrl_ff.lower_en}}});
   assign evt_new[1] = |(edge_ev[15:8] & pin_en_ff);
   assign evt_new[2] = ctrl_ff.third_en && (|edge_ev[20:16]);

   // sticky status, write one to clear, set wins
   assign nxt_evt_stat = (evt_stat_ff & ~(wr_evt_clr ? bus_i.wdata[2:0] : 3'h0)) | evt_new;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_stat_ff <= `EVT_RESET;
         port_irq_ff <= 3'h0;
         irq_ff <= 1'b0;
      end else begin
         evt_stat_ff <= nxt_evt_stat;
         port_irq_ff <= nxt_port_irq;
         irq_ff <= |(nxt_evt_stat & nxt_evt_en);
      end
   end

   // ----------------------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------------------
   // data stand for one cycle only, then drop to zero
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_ff <= 8'h00;
      end else if (bus_i.re) begin
         case (bus_i.addr)
            `FIRST_FLAG_ADDR: rd_ff <= flag_ff[7:0];
            `SECOND_FLAG_ADDR: rd_ff <= flag_ff[15:8];
            `THIRD_FLAG_ADDR: rd_ff <= {3'h0, flag_ff[20:16]};
            `PIN_CTRL_ADDR: rd_ff <= {1'b0, ctrl_ff};
            `SECOND_PIN_EN_ADDR: rd_ff <= pin_en_ff;
            `EVT_STATUS_ADDR: rd_ff <= {5'h00, evt_stat_ff};
            `EVT_ENABLE_ADDR: rd_ff <= {5'h00, evt_en_ff};
            default: rd_ff <= 8'h00;
         endcase
      end else begin
         rd_ff <= 8'h00;
      end
   end

   // outputs straight from flip-flops
   assign rd_data_o = rd_ff;
   assign irq_o = irq_ff;
   assign port_irq_o = port_irq_ff;
   assign ctrl_o = ctrl_ff;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   sequence s_ctrl_read;
      bus_i.re && (bus_i.addr == `PIN_CTRL_ADDR);
   endsequence

   sequence s_first_clear0;
      wr_first && !bus_i.wdata[0] && !edge_ev[0];
   endsequence

   a_third_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ctrl_ff.third_en |-> !port_irq_ff[2]) else $error("third port request while off");
   a_upper_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ctrl_ff.upper_en && (flag_ff[3:0] == 4'h0) |-> !port_irq_ff[0])
      else $error("upper lines request while off");
   a_lower_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ctrl_ff.lower_en && (flag_ff[7:4] == 4'h0) |-> !port_irq_ff[0])
      else $error("lower lines request while off");
   a_third_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ctrl_ff.third_edge && fall[16] |=> flag_ff[16]) else $error("third falling edge lost");
   a_second_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ctrl_ff.second_edge && rise[8] |=> flag_ff[8]) else $error("second rising edge lost");
   a_first_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ctrl_ff.first_edge && fall[0] |=> flag_ff[0]) else $error("first falling edge lost");
   a_resume_route: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      HAS_USB && !ctrl_ff.first_edge && usb_resume_i && !usb_prev_ff |=> flag_ff[7])
      else $error("resume not flagged on line 7");
   a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_first_clear0 |=> !flag_ff[0]) else $error("flag not cleared by zero write");
   a_spare_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      HAS_USB |-> !flag_ff[6]) else $error("unused flag set");
   a_pin_enable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (pin_en_ff == 8'h00) |-> !port_irq_ff[1]) else $error("masked second port request");
   a_ctrl_top: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_ctrl_read |=> !rd_data_o[7] && (rd_data_o[6:0] == $past(ctrl_ff)))
      else $error("control readback wrong");

   // a write of one must leave a set flag alone
   sequence s_second_keep;
      wr_second && bus_i.wdata[0] && flag_ff[8];
   endsequence

   // zero write and edge in one cycle; the edge must not be lost
   sequence s_second_race;
      wr_second && !bus_i.wdata[0] && edge_ev[8];
   endsequence

   // selected polarity, the other edge on each port
   a_second_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ctrl_ff.second_edge && fall[15] |=> flag_ff[15])
      else $error("second falling edge lost");
   a_third_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ctrl_ff.third_edge && rise[20] |=> flag_ff[20])
      else $error("third rising edge lost");
   a_first_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ctrl_ff.first_edge && rise[5] |=> flag_ff[5])
      else $error("first rising edge lost");

   // the other edge leaves a clear flag clear
   a_third_ignore: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ctrl_ff.third_edge && fall[16] && !flag_ff[16] |=> !flag_ff[16])
      else $error("third falling edge flagged while rising selected");

   // an enabled group with a pending flag must request
   a_upper_req: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ctrl_ff.upper_en && flag_ff[5] |-> port_irq_ff[0])
      else $error("upper lines request missing");
   a_lower_req: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ctrl_ff.lower_en && flag_ff[0] |-> port_irq_ff[0])
      else $error("lower lines request missing");
   a_third_req: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ctrl_ff.third_en && flag_ff[20] |-> port_irq_ff[2])
      else $error("third port request missing");
   a_pin_req: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      pin_en_ff[7] && flag_ff[15] |-> port_irq_ff[1])
      else $error("enabled second port pin gives no request");

   // control writes store bits 6 to 0, spare bit included
   a_spare_store: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_ctrl |=> (ctrl_o == $past(bus_i.wdata[6:0])))
      else $error("control write not stored");

   // flag write semantics
   a_flag_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_second_keep |=> flag_ff[8])
      else $error("flag cleared by a one write");
   a_set_wins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_second_race |=> flag_ff[8])
      else $error("edge lost against a same-cycle clear");

   // on the usb build the line 7 pin itself never flags
   a_pin7_ignored: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      HAS_USB && !usb_rise && !usb_fall && !flag_ff[7] |=> !flag_ff[7])
      else $error("line 7 flagged without resume");
endmodule
`default_nettype wire

// [sim/pin_model.sv]
// external pin sources driving the three input ports
`timescale 1ns/1ps
`default_nettype none
module pin_model (
   input wire logic sys_clk_i, // system clock
   output logic [7:0] first_o, // first port pins
   output logic [7:0] second_o, // second port pins
   output logic [4:0] third_o // third port pins
);
   // --------------------------------------------------------------------
   // pin levels
   // --------------------------------------------------------------------
   // all pins start low so the first rise is a clean edge
   initial begin
      first_o = 8'h00;
      second_o = 8'h00;
      third_o = 5'h00;
   end

   // new levels land after an edge and hold long past the filter depth
   task automatic set_pins(input logic [7:0] f, input logic [7:0] s, input logic [4:0] t);
      @(posedge sys_clk_i);
      first_o <= f;
      second_o <= s;
      third_o <= t;
      repeat (7) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// register and pin level test of the port pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pin_irq_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   bus_req_t bus = '0;
   logic usb_resume = 1'b0;
   logic [7:0] rd_data;
   logic [7:0] first_pins;
   logic [7:0] second_pins;
   logic [4:0] third_pins;
   logic irq;
   logic [2:0] port_irq;
   pin_ctrl_t ctrl;
   int error_cnt = 0;
   int total_checks = 0;
   logic [7:0] reset_addr [7] = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h92};

   // --------------------------------------------------------------------
   // clock, parts
   // --------------------------------------------------------------------
   // 10 MHz system clock
   always #50 sys_clk = ~sys_clk;

   pin_model pin_u (
      .sys_clk_i(sys_clk),
      .first_o(first_pins),
      .second_o(second_pins),
      .third_o(third_pins)
   );

   port_pin_interrupt_control dut_u (
      .sys_clk_i(sys_clk),
      .rst_n_i(rst_n),
      .bus_i(bus),
      .rd_data_o(rd_data),
      .first_port_i(first_pins),
      .second_port_i(second_pins),
      .third_port_i(third_pins),
      .usb_resume_i(usb_resume),
      .irq_o(irq),
      .port_irq_o(port_irq),
      .ctrl_o(ctrl)
   );

   // --------------------------------------------------------------------
   // tasks
   // --------------------------------------------------------------------
   task automatic report_and_stop();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one-cycle write strobe, ends settled mid-cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= {a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus <= '0;
      @(negedge sys_clk);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus <= {a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus <= '0;
      @(negedge sys_clk);
      chk($sformatf("reg %h", a), exp, rd_data);
   endtask

   task automatic chk_req(input logic [2:0] exp_port, input logic exp_irq);
      chk("port_irq", {5'h00, exp_port}, {5'h00, port_irq});
      chk("irq", {7'h00, exp_irq}, {7'h00, irq});
   endtask

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      report_and_stop();
   end

   // --------------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      // reset values, unmapped and odd bits
      foreach (reset_addr[i]) rd(reset_addr[i], 8'h00);
      rd(8'h00, 8'h00);
      wr(8'h8c, 8'hff);
      rd(8'h8c, 8'h7f);
      chk("ctrl", 8'h7f, {1'b0, ctrl});
      wr(8'h8c, 8'h00);
      // rising edges with every enable off set flags but no request
      pin_u.set_pins(8'h21, 8'h81, 5'h11);
      rd(8'h89, 8'h21);
      rd(8'h8a, 8'h81);
      rd(8'h8b, 8'h11);
      chk_req(3'b000, 1'b0);
      // writing 1 leaves flags, writing 0 clears them
      wr(8'h8a, 8'hff);
      rd(8'h8a, 8'h81);
      wr(8'h89, 8'h00);
      wr(8'h8a, 8'h00);
      wr(8'h8b, 8'h00);
      rd(8'h89, 8'h00);
      rd(8'h8a, 8'h00);
      rd(8'h8b, 8'h00);
      // falling edges ignored while rising is selected
      pin_u.set_pins(8'h00, 8'h00, 5'h00);
      rd(8'h89, 8'h00);
      rd(8'h8a, 8'h00);
      rd(8'h8b, 8'h00);
      // falling select: rises ignored, falls flagged
      wr(8'h8c, 8'h07);
      pin_u.set_pins(8'h21, 8'h81, 5'h11);
      rd(8'h89, 8'h00);
      rd(8'h8a, 8'h00);
      rd(8'h8b, 8'h00);
      pin_u.set_pins(8'h00, 8'h00, 5'h00);
      rd(8'h89, 8'h21);
      rd(8'h8a, 8'h81);
      rd(8'h8b, 8'h11);
      // group enables: keep only the upper-half flag of the first port
      wr(8'h89, 8'h20);
      wr(8'h8c, 8'h0f);
      chk_req(3'b000, 1'b0);
      wr(8'h8c, 8'h17);
      chk_req(3'b001, 1'b0);
      wr(8'h8c, 8'h27);
      chk_req(3'b100, 1'b0);
      wr(8'h8c, 8'h07);
      chk_req(3'b000, 1'b0);
      wr(8'h8d, 8'h80);
      chk_req(3'b010, 1'b0);
      // enable a second port pin whose flag is clear
      wr(8'h8d, 8'h02);
      chk_req(3'b000, 1'b0);
      // event status, enable mask and write-one clear
      wr(8'h89, 8'h00);
      wr(8'h8c, 8'h08);
      wr(8'h92, 8'h01);
      pin_u.set_pins(8'h01, 8'h00, 5'h00);
      rd(8'h90, 8'h01);
      chk_req(3'b001, 1'b1);
      wr(8'h92, 8'h00);
      chk_req(3'b001, 1'b0);
      wr(8'h92, 8'h01);
      chk_req(3'b001, 1'b1);
      wr(8'h90, 8'h00);
      rd(8'h90, 8'h01);
      rd(8'h91, 8'h00);
      wr(8'h91, 8'h01);
      rd(8'h90, 8'h00);
      chk_req(3'b001, 1'b0);
      // resume source on line 7, first edge select kept rising
      wr(8'h89, 8'h00);
      wr(8'h8c, 8'h10);
      pin_u.set_pins(8'hc1, 8'h00, 5'h00);
      rd(8'h89, 8'h00);
      @(posedge sys_clk);
      usb_resume <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(8'h89, 8'h80);
      // event enable for the first port is still on, so irq follows
      chk_req(3'b001, 1'b1);
      @(posedge sys_clk);
      usb_resume <= 1'b0;
      // resume falling is not the selected edge: flag unchanged
      rd(8'h89, 8'h80);
      report_and_stop();
   end
endmodule
`default_nettype wire
